// *** rtl/pms_power_mode_sequencer.v ***
// Operation
// - Three power modes plus a power-on-reset condition with everything off.
// - After supply power-on reset the device settles in SHUTDOWN.
// - SHUTDOWN keeps functions off and only watches for a wake ping or tone and a hard reset ping.
// - Converters, ports, chain comm, timeouts, SPI, OTP, module balancing: ACTIVE only.
// - SLEEP runs protectors, balancing, fault signalling, thermal detect, sleep timeout.
// - The power-on detect block runs in SHUTDOWN, SLEEP and ACTIVE.
// - Base device wake from SHUTDOWN sets digital reset, upstream fault and host-port-cleared flags.
// - Middle stack device wake from SHUTDOWN sets digital reset and upstream fault flags.
// - Top of stack wake sets only the digital reset flag.
// - A go-shutdown command moves the device to SHUTDOWN.
// - SLEEP is entered only from ACTIVE, by command or communication timeout.
// - In SLEEP, wake goes ACTIVE with digital reset; sleep-exit goes ACTIVE with host-port reset instead.
// - Hard reset turns all but the reference off for an interval, then SHUTDOWN.
`timescale 1ns/1ns
`default_nettype none
`include "pms_consts.vh"

module pms_power_mode_sequencer #(
  parameter HARD_RESET_NS = `PMS_HARD_RESET_NS
) (
  input  wire                      clk_sys,
  input  wire                      reset,
  input  wire                      isBase,
  input  wire                      isTop,
  input  wire                      wakePing,
  input  wire                      sleepExitPing,
  input  wire                      shutdownPing,
  input  wire                      hardResetPing,
  input  wire                      goShutdownBit,
  input  wire                      goSleepBit,
  input  wire                      commTimeout,
  input  wire                      commTimeoutToSleep,
  input  wire                      balanceDone,
  input  wire                      balanceDoneShutdownEn,
  input  wire                      thermalShutdown,
  input  wire [2:0]                sleepTimeoutSel,
  input  wire [2:0]                armFunctions,
  input  wire                      clearDigitalResetFlag,
  input  wire                      clearUpstreamFaultFlag,
  input  wire                      clearHostPortClearedFlag,
  output reg  [2:0]                powerState,
  output reg  [`PMS_AO_WIDTH-1:0]  activeOnlyEn,
  output reg  [`PMS_LP_WIDTH-1:0]  lowPowerEn,
  output reg                       porDetectEn,
  output reg                       alwaysOnReferenceEn,
  output reg                       digitalResetPulse,
  output reg                       hostPortResetPulse,
  output reg                       digital_reset_flag,
  output reg                       upstream_fault_flag,
  output reg                       host_port_cleared_flag
);

  // Hard reset interval as a least time, rounded up to whole cycles.
  // Worked out at full integer width first, then cut to the timer width on purpose.
  localparam integer HARD_RESET_CYCLES_INT =
    (HARD_RESET_NS + `PMS_CLK_PERIOD_NS - 1) / `PMS_CLK_PERIOD_NS;
  localparam [15:0]  HARD_RESET_CYCLES     = HARD_RESET_CYCLES_INT[15:0];

  reg  [2:0]  next_powerState;
  reg         next_digitalReset;
  reg         next_hostPortReset;
  reg         next_setDigital;
  reg         next_setUpstream;
  reg         next_setHostCleared;
  reg  [15:0] slowDivider;
  reg         slowTick;
  wire        hardResetDone;
  wire        sleepTimeoutHit;
  wire        inActive = (powerState == `PMS_ST_ACTIVE);
  wire        inSleep  = (powerState == `PMS_ST_SLEEP);
  wire        stackMiddle = !isBase && !isTop;
  wire [15:0] sleepLimit = `PMS_SLEEP_BASE_TICKS << sleepTimeoutSel;

  // Slow time base for the sleep timeout, one enable pulse per period.
  always @(posedge clk_sys) begin
    if (reset) begin
      slowDivider <= 16'h0000;
      slowTick    <= 1'b0;
    end else if (slowDivider == `PMS_SLOW_TICK_CYCLES - 16'h0001) begin
      slowDivider <= 16'h0000;
      slowTick    <= 1'b1;
    end else begin
      slowDivider <= slowDivider + 16'h0001;
      slowTick    <= 1'b0;
    end
  end

  // The hard reset hold time restarts whenever the state is not the hold state.
  pms_interval_timer #(
    .WIDTH       (16)
  ) hardResetTimer (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .restart     (powerState != `PMS_ST_HARD_RESET),
    .countEnable (1'b1),
    .limit       (HARD_RESET_CYCLES),
    .expired     (hardResetDone)
  );

  // Sleep timeout counts slow ticks only while asleep; a zero select disables it.
  pms_interval_timer #(
    .WIDTH       (16)
  ) sleepTimer (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .restart     (!inSleep),
    .countEnable (slowTick && sleepTimeoutSel != 3'h0),
    .limit       (sleepLimit),
    .expired     (sleepTimeoutHit)
  );

  // Transition decode; a hard reset outranks every other event in any mode.
  always @* begin
    next_powerState     = powerState;
    next_digitalReset   = 1'b0;
    next_hostPortReset  = 1'b0;
    next_setDigital     = 1'b0;
    next_setUpstream    = 1'b0;
    next_setHostCleared = 1'b0;
    case (powerState)
      `PMS_ST_POR: begin
        next_powerState = `PMS_ST_SHUTDOWN;
      end
      `PMS_ST_SHUTDOWN: begin
        // Only a wake ping or tone and a hard reset ping are heard here; everything else is ignored.
        if (hardResetPing) begin
          next_powerState = `PMS_ST_HARD_RESET;
        end else if (wakePing) begin
          next_powerState     = `PMS_ST_ACTIVE;
          next_digitalReset   = 1'b1;
          next_hostPortReset  = 1'b1;
          next_setDigital     = 1'b1;
          next_setUpstream    = isBase || stackMiddle;
          next_setHostCleared = isBase;
        end
      end
      `PMS_ST_SLEEP: begin
        if (hardResetPing) begin
          next_powerState = `PMS_ST_HARD_RESET;
        end else if (thermalShutdown || shutdownPing || sleepTimeoutHit) begin
          next_powerState = `PMS_ST_SHUTDOWN;
        end else if (wakePing) begin
          next_powerState   = `PMS_ST_ACTIVE;
          next_digitalReset = 1'b1;
          next_setDigital   = 1'b1;
        end else if (sleepExitPing) begin
          next_powerState     = `PMS_ST_ACTIVE;
          next_hostPortReset  = 1'b1;
          next_setHostCleared = isBase;
        end
      end
      `PMS_ST_ACTIVE: begin
        // Commands and communication timeouts count only here, so they are simply not decoded elsewhere.
        if (hardResetPing) begin
          next_powerState = `PMS_ST_HARD_RESET;
        end else if (thermalShutdown || shutdownPing) begin
          next_powerState = `PMS_ST_SHUTDOWN;
        end else if (goShutdownBit) begin
          next_powerState = `PMS_ST_SHUTDOWN;
        end else if (commTimeout) begin
          next_powerState = commTimeoutToSleep ? `PMS_ST_SLEEP
                                               : `PMS_ST_SHUTDOWN;
        end else if (balanceDone && balanceDoneShutdownEn) begin
          next_powerState = `PMS_ST_SHUTDOWN;
        end else if (goSleepBit) begin
          next_powerState = `PMS_ST_SLEEP;
        end else if (wakePing) begin
          next_digitalReset = 1'b1;
          next_setDigital   = 1'b1;
        end else if (sleepExitPing) begin
          next_hostPortReset  = 1'b1;
          next_setHostCleared = isBase;
        end
      end
      `PMS_ST_HARD_RESET: begin
        if (hardResetDone) begin
          next_powerState = `PMS_ST_SHUTDOWN;
        end
      end
      default: begin
        next_powerState = `PMS_ST_POR;
      end
    endcase
  end

  // State register and the one-cycle reset pulses toward the digital core.
  always @(posedge clk_sys) begin
    if (reset) begin
      powerState         <= `PMS_ST_POR;
      digitalResetPulse  <= 1'b0;
      hostPortResetPulse <= 1'b0;
    end else begin
      powerState         <= next_powerState;
      digitalResetPulse  <= next_digitalReset;
      hostPortResetPulse <= next_hostPortReset;
    end
  end

  // Wake flags: setting beats a simultaneous clear, and clears only count in ACTIVE.
  always @(posedge clk_sys) begin
    if (reset) begin
      digital_reset_flag     <= 1'b0;
      upstream_fault_flag    <= 1'b0;
      host_port_cleared_flag <= 1'b0;
    end else begin
      if (next_setDigital) begin
        digital_reset_flag <= 1'b1;
      end else if (inActive && clearDigitalResetFlag) begin
        digital_reset_flag <= 1'b0;
      end
      if (next_setUpstream) begin
        upstream_fault_flag <= 1'b1;
      end else if (inActive && clearUpstreamFaultFlag) begin
        upstream_fault_flag <= 1'b0;
      end
      if (next_setHostCleared) begin
        host_port_cleared_flag <= 1'b1;
      end else if (inActive && clearHostPortClearedFlag) begin
        host_port_cleared_flag <= 1'b0;
      end
    end
  end

  // Function enables follow the state being entered, so they change with the state.
  // Balancing and protectors in SLEEP only run if armed beforehand; arming is
  // sampled only while ACTIVE so a change made while asleep has no effect.
  reg [2:0] armed;
  always @(posedge clk_sys) begin
    if (reset) begin
      armed <= 3'h0;
    end else if (inActive) begin
      armed <= armFunctions;
    end
  end

  wire nextActive = (next_powerState == `PMS_ST_ACTIVE);
  wire nextSleep  = (next_powerState == `PMS_ST_SLEEP);
  wire nextLive   = nextActive || nextSleep;
  wire [2:0] nextArm = nextActive ? armFunctions : armed;

  always @(posedge clk_sys) begin
    if (reset) begin
      activeOnlyEn        <= {`PMS_AO_WIDTH{1'b0}};
      lowPowerEn          <= {`PMS_LP_WIDTH{1'b0}};
      porDetectEn         <= 1'b0;
      alwaysOnReferenceEn <= 1'b0;
    end else begin
      activeOnlyEn <= {`PMS_AO_WIDTH{nextActive}};
      lowPowerEn[`PMS_LP_VOLT_PROT] <= nextLive && nextArm[`PMS_ARM_VOLT];
      lowPowerEn[`PMS_LP_TEMP_PROT] <= nextLive && nextArm[`PMS_ARM_TEMP];
      lowPowerEn[`PMS_LP_CELL_BAL]  <= nextLive && nextArm[`PMS_ARM_BAL];
      lowPowerEn[`PMS_LP_BAL_OT]    <= nextLive && nextArm[`PMS_ARM_BAL];
      lowPowerEn[`PMS_LP_FAULT_SIG] <= nextLive;
      lowPowerEn[`PMS_LP_THERM_DET] <= nextLive;
      lowPowerEn[`PMS_LP_SLEEP_TMO] <= nextSleep;
      porDetectEn <= nextLive || next_powerState == `PMS_ST_SHUTDOWN;
      alwaysOnReferenceEn <= next_powerState != `PMS_ST_POR;
    end
  end

endmodule // pms_power_mode_sequencer

`default_nettype wire

// *** rtl/pms_consts.vh ***
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

// Power state codes.
`define PMS_ST_POR         3'h0
`define PMS_ST_SHUTDOWN    3'h1
`define PMS_ST_SLEEP       3'h2
`define PMS_ST_ACTIVE      3'h3
`define PMS_ST_HARD_RESET  3'h4

// Bit positions in the active-only enable vector.
`define PMS_AO_MAIN_CONV   0
`define PMS_AO_AUX_CONV    1
`define PMS_AO_HOST_PORT   2
`define PMS_AO_CHAIN_COMM  3
`define PMS_AO_COMM_TMO    4
`define PMS_AO_SPI_MASTER  5
`define PMS_AO_OTP_PROG    6
`define PMS_AO_MOD_BAL     7
`define PMS_AO_WIDTH       8

// Bit positions in the low-power enable vector.
`define PMS_LP_VOLT_PROT   0
`define PMS_LP_TEMP_PROT   1
`define PMS_LP_CELL_BAL    2
`define PMS_LP_BAL_OT      3
`define PMS_LP_FAULT_SIG   4
`define PMS_LP_THERM_DET   5
`define PMS_LP_SLEEP_TMO   6
`define PMS_LP_WIDTH       7

// Bit positions in the arming input.
`define PMS_ARM_VOLT       0
`define PMS_ARM_TEMP       1
`define PMS_ARM_BAL        2

// Timing.
`define PMS_CLK_PERIOD_NS     8
`define PMS_HARD_RESET_NS     10000
`define PMS_SLOW_TICK_CYCLES  16'h04e2
`define PMS_SLEEP_BASE_TICKS  16'h0040

`endif

// *** rtl/pms_interval_timer.v ***
`timescale 1ns/1ns
`default_nettype none

// Counts enabled steps up to a limit and pulses once when the limit is reached.
module pms_interval_timer #(
  parameter WIDTH = 16
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire             restart,
  input  wire             countEnable,
  input  wire [WIDTH-1:0] limit,
  output reg              expired
);

  reg [WIDTH-1:0] count;
  wire [WIDTH-1:0] countPlusOne = count + {{(WIDTH-1){1'b0}}, 1'b1};

  // Holding at the limit keeps the expiry a single pulse per run.
  always @(posedge clk_sys) begin
    expired <= 1'b0;
    if (reset || restart) begin
      count <= {WIDTH{1'b0}};
    end else if (countEnable && count != limit) begin
      count <= countPlusOne;
      if (countPlusOne == limit) begin
        expired <= 1'b1;
      end
    end
  end

endmodule // pms_interval_timer

`default_nettype wire

// *** sim/pms_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host side ping and tone drivers; each request becomes a one-cycle detect pulse.
module pms_host_model (
  input  wire       clk_sys,
  input  wire       go,
  input  wire [1:0] sel,
  output var logic  wakePing,
  output var logic  sleepExitPing,
  output var logic  shutdownPing,
  output var logic  hardResetPing
);
  // Pings only, since a sleeping or shut-down device cannot hear commands.
  initial {wakePing, sleepExitPing, shutdownPing, hardResetPing} = 4'h0;
  always @(posedge clk_sys) begin
    wakePing      <= go && sel == 2'h0;
    sleepExitPing <= go && sel == 2'h1;
    shutdownPing  <= go && sel == 2'h2;
    hardResetPing <= go && sel == 2'h3;
  end
endmodule // pms_host_model
`default_nettype wire

// *** sim/pms_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
// Port-level watch on the mode controller; hard reset bounds assume HARD_RESET_NS of 80.
module pms_asserts #(
  parameter HARD_RESET_NS = 80
) (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       isBase,
  input wire logic       isTop,
  input wire logic       wakePing,
  input wire logic       hardResetPing,
  input wire logic       clearDigitalResetFlag,
  input wire logic [2:0] powerState,
  input wire logic [7:0] activeOnlyEn,
  input wire logic [6:0] lowPowerEn,
  input wire logic       porDetectEn,
  input wire logic       alwaysOnReferenceEn,
  input wire logic       digital_reset_flag,
  input wire logic       upstream_fault_flag,
  input wire logic       host_port_cleared_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // A wake seen in SHUTDOWN; hard reset outranks it.
  wire wakeDown = powerState == 3'h1 && wakePing && !hardResetPing;
  a_por_to_shutdown: assert property (powerState == 3'h0 |=> powerState == 3'h1)
    else $error("No SHUTDOWN after power-on reset.");
  a_active_only_en: assert property (
    activeOnlyEn == ((powerState == 3'h3) ? 8'hff : 8'h00))
    else $error("Active-only enables wrong for state.");
  a_low_power_en: assert property (
    (lowPowerEn[4] == (powerState inside {3'h2, 3'h3}))
    && (!lowPowerEn[6] || powerState == 3'h2))
    else $error("Low-power enables wrong for state.");
  a_por_detect_on: assert property (
    porDetectEn == (powerState inside {3'h1, 3'h2, 3'h3}))
    else $error("Power-on detect enable wrong.");
  // Flags are sticky and clears are ignored in SHUTDOWN, so an old set flag may survive a wake.
  a_wake_flags: assert property (wakeDown |=>
    powerState == 3'h3 && digital_reset_flag
    && upstream_fault_flag == (!$past(isTop) || $past(upstream_fault_flag))
    && host_port_cleared_flag == ($past(isBase) || $past(host_port_cleared_flag)))
    else $error("Wake from SHUTDOWN flags wrong.");
  a_shutdown_idle: assert property (
    powerState == 3'h1 && !wakeDown && !hardResetPing |=> powerState == 3'h1)
    else $error("SHUTDOWN left without wake.");
  a_sleep_from_act: assert property (
    $rose(powerState == 3'h2) |-> $past(powerState) == 3'h3)
    else $error("SLEEP entered from a mode other than ACTIVE.");
  a_hard_reset_seq: assert property (
    hardResetPing && porDetectEn |=>
    (powerState == 3'h4 && alwaysOnReferenceEn && !porDetectEn) [*8]
    ##[1:6] powerState == 3'h1)
    else $error("Hard reset sequence wrong.");
  a_flag_sticky: assert property (
    digital_reset_flag && !hardResetPing && powerState != 3'h4
    && !(clearDigitalResetFlag && powerState == 3'h3) |=> digital_reset_flag)
    else $error("Digital reset flag dropped.");
  c_wake: cover property (wakeDown);
  c_sleep: cover property ($rose(powerState == 3'h2));
  c_hard: cover property (powerState == 3'h4);
endmodule // pms_asserts
bind pms_power_mode_sequencer pms_asserts #(.HARD_RESET_NS(HARD_RESET_NS)) u_pms_asserts (.*);
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       isBase = 1'b0;
  logic       isTop = 1'b0;
  logic       go = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [5:0] ev = 6'h00;
  logic [2:0] arm = 3'h0;
  logic       toSleep = 1'b0;
  wire        wakeP, exitP, downP, hardP, porEn, refEn, dPulse, hPulse, digF, upF, hostF;
  wire  [2:0] st;
  wire  [7:0] aoEn;
  wire  [6:0] lpEn;
  int         err_total = 0;
  int         n_compared = 0;
  always #4 clk_sys = ~clk_sys;
  pms_host_model u_pms_host_model (.clk_sys(clk_sys), .go(go), .sel(sel), .wakePing(wakeP),
    .sleepExitPing(exitP), .shutdownPing(downP), .hardResetPing(hardP));
  // Balancing-end and thermal inputs are tied; their paths are left to other benches.
  pms_power_mode_sequencer #(.HARD_RESET_NS(80)) u_pms_power_mode_sequencer (
    .clk_sys(clk_sys), .reset(reset), .isBase(isBase), .isTop(isTop), .wakePing(wakeP),
    .sleepExitPing(exitP), .shutdownPing(downP), .hardResetPing(hardP),
    .goShutdownBit(ev[1]), .goSleepBit(ev[0]), .commTimeout(ev[2]),
    .commTimeoutToSleep(toSleep), .balanceDone(1'b0), .balanceDoneShutdownEn(1'b0),
    .thermalShutdown(1'b0), .sleepTimeoutSel(3'h0), .armFunctions(arm),
    .clearDigitalResetFlag(ev[3]), .clearUpstreamFaultFlag(ev[4]),
    .clearHostPortClearedFlag(ev[5]), .powerState(st), .activeOnlyEn(aoEn),
    .lowPowerEn(lpEn), .porDetectEn(porEn), .alwaysOnReferenceEn(refEn),
    .digitalResetPulse(dPulse), .hostPortResetPulse(hPulse), .digital_reset_flag(digF),
    .upstream_fault_flag(upF), .host_port_cleared_flag(hostF));
  // Expected wake flags {digital, upstream, host port} by chain position 0 base, 2 top.
  function automatic logic [2:0] wakeFlags(input int pos);
    wakeFlags = {1'b1, pos != 2, pos == 0};
  endfunction
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // Ping request; the design takes it two edges later, checked just after.
  task automatic ping(input logic [1:0] s);
    @(posedge clk_sys) {go, sel} <= {1'b1, s};
    @(posedge clk_sys) go <= 1'b0;
    @(posedge clk_sys) #1;
  endtask
  // One-cycle command or clear pulse, taken at the second edge.
  task automatic pulse(input logic [5:0] v);
    @(posedge clk_sys) ev <= v;
    @(posedge clk_sys) ev <= 6'h00;
    #1;
  endtask
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    int pos, i;
    pos = $urandom(79108);
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys) #1;
    chk({st, refEn, porEn, aoEn[4:0]}, {3'h1, 2'h3, 5'h00});
    for (pos = 0; pos < 3; pos++) begin
      @(posedge clk_sys) isBase <= (pos == 0);
      isTop <= (pos == 2);
      ping(2'h1);
      chk(st, 3'h1);
      ping(2'h0);
      chk({st, dPulse, hPulse}, {3'h3, 2'h3});
      chk({digF, upF, hostF}, wakeFlags(pos));
      chk(aoEn, 8'hff);
      repeat (1 + $urandom % 6) @(posedge clk_sys);
      #1 chk({digF, upF, hostF}, wakeFlags(pos));
      pulse(6'h38);
      chk({digF, upF, hostF}, 3'h0);
      @(posedge clk_sys) arm <= 3'($urandom);
      pulse(6'h01);
      chk({st, lpEn}, {3'h2, 3'h7, arm[2], arm});
      chk(aoEn, 8'h00);
      pulse(6'h02);
      chk(st, 3'h2);
      ping(pos == 1 ? 2'h0 : 2'h1);
      chk({st, hPulse}, {3'h3, pos != 1});
      chk({digF, upF, hostF}, {pos == 1, 1'b0, pos == 0});
      pulse(6'h38);
      // Both timeout targets are forced once so each path is sure to run.
      @(posedge clk_sys) toSleep <= (pos == 2) ? 1'($urandom % 2) : (pos == 0);
      pulse(6'h04);
      chk(st, toSleep ? 3'h2 : 3'h1);
      if (toSleep) ping(2'h1);
      // Sleep-exit sets the host flag on the base; clear it so the next wake starts clean.
      if (toSleep) pulse(6'h38);
      if (toSleep) pulse(6'h02);
      chk(st, 3'h1);
    end
    // A shutdown ping leaves ACTIVE at once and is not heard in SHUTDOWN.
    ping(2'h0);
    chk(st, 3'h3);
    ping(2'h2);
    chk(st, 3'h1);
    ping(2'h2);
    chk(st, 3'h1);
    ping(2'h3);
    chk({st, refEn, porEn, aoEn[4:0]}, {3'h4, 2'h2, 5'h00});
    for (i = 0; i < 40 && st !== 3'h1; i++) @(posedge clk_sys) #1;
    chk(st, 3'h1);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
